// File: src/smr_top.sv
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Operation
// - disable bit opens switch, now or delayed
// - with adapter, ship-with-input then disable opens switch, ship on removal
// - ship exit on plug, clear, reset, button
// - button exit sets hiz request; plug clears
// - system reset needs enable set, disable clear
// - completed system reset restores power-on defaults
// - qualified button low opens switch off-time
// - reset-with-input: hiz first, then power cycle
// - otherwise reset waits for adapter removal
// - power up after reset only without hiz
// - power good flag is AND of conditions
// - indicator low while charging, released otherwise
// - indicator blinks 1 Hz during charge suspend
// - an event with no alert running gives one 256 us alert
// - alert sources: input, removal, detect, faults
// - fault and status latched until host reads
// - pending latched ones suppress further fault and status alerts
// - first read old state, second read present
// - accessory valid rises on good adapter input
// - accessory valid drops on overcurrent, overvoltage
// - accessory valid low before boost starts
// - boost: valid follows rail window, exit causes
module smr_top import smr_pkg::*; #(
    parameter int unsigned EXIT_CYC = EXIT_DEGLITCH_CYC,
    parameter int unsigned QUAL_CYC = RESET_QUALIFY_CYC,
    parameter int unsigned OFF_CYC = RESET_OFF_CYC,
    parameter int unsigned DLY_CYC = DISABLE_DELAY_CYC,
    parameter int unsigned ALERT_CYC = ALERT_PULSE_CYC,
    parameter int unsigned BLINK_CYC = BLINK_HALF_CYC
) (
    input wire logic REF_CLK_I,
    input wire logic SRST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WR_DATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RD_DATA_O,
    input wire logic PUSH_BUTTON_N_I,
    input wire smr_sense_t SENSE_I,
    output logic BATTERY_SWITCH_ON_O,
    output logic HIZ_MODE_O,
    output logic BOOST_ENABLE_O,
    output logic CHARGE_IND_O,
    output logic CHARGE_IND_OE_O,
    output logic HOST_ALERT_N_O,
    output logic ACCESSORY_POWER_VALID_O
);
    typedef enum logic [2:0] {
        ST_ON, ST_DELAY, ST_OPEN_ADP, ST_SHIP, ST_RST_WAIT, ST_RST_HIZ, ST_RST_OFF, ST_HOLD
    } smr_state_t;

    // two-stage synchronisers; stage one is read only by stage two
    smr_sense_t s_meta_r, s_r, s_prev_r;
    logic btn_meta_r, btn_r;
    smr_state_t state_r, state_nxt;
    smr_ctrl_t ctrl_r, ctrl_nxt;
    logic [31:0] btn_cnt_r, tmr_r, blink_cnt_r, alert_cnt_r, alert_cnt_nxt;
    logic blink_r;
    logic hiz_at_start_r;   // hiz request seen when the reset began
    logic pg_r, boost_r, boost_nxt, apv_nxt, ind_oe_nxt;
    logic [7:0] fault_lat_r;
    logic [2:0] stat_lat_r;
    logic sw_on_r, hiz_r, alert_n_r, ind_oe_r, apv_r;
    logic [31:0] rd_data_r;

    // synchronise the sense inputs and the push-button pin; bus and SRST_I are used as they come
    always_ff @(posedge REF_CLK_I) begin
        s_meta_r <= SENSE_I;
        s_r <= s_meta_r;
        s_prev_r <= s_r;
        btn_meta_r <= PUSH_BUTTON_N_I;
        btn_r <= btn_meta_r;
    end

    // bus decode
    wire wr_ctrl = WR_I && (ADDR_I == OFS_CTRL);
    wire rd_fault = RD_I && (ADDR_I == OFS_FAULT);
    wire rd_status = RD_I && (ADDR_I == OFS_STATUS);
    wire reg_reset_wr = wr_ctrl && WR_DATA_I[REG_RESET_BIT];

    // button low-time counter, saturating at the qualify count
    wire btn_low = !btn_r;
    wire exit_evt = btn_low && (btn_cnt_r == EXIT_CYC - 1);
    wire qual_evt = btn_low && (btn_cnt_r == QUAL_CYC - 1);
    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I || !btn_low) begin
            btn_cnt_r <= 32'h0;
        end else if (btn_cnt_r < QUAL_CYC) begin
            btn_cnt_r <= btn_cnt_r + 32'h1;
        end
    end

    // event decode
    wire adp = s_r.adapter_present;
    wire adp_rise = adp && !s_prev_r.adapter_present;
    wire adp_fall = !adp && s_prev_r.adapter_present;
    wire dis = ctrl_r.battery_switch_disable;
    wire rst_en = ctrl_r.system_reset_enable && !dis;
    wire rst_go = qual_evt && rst_en;
    wire rst_now = ctrl_r.reset_with_input_select || !adp;
    wire open_go = !adp || ctrl_r.ship_with_input_select;
    wire [2:0] open_tgt = adp ? ST_OPEN_ADP : ST_SHIP;  // full state code, one bit would alias
    wire ship_exit = (state_r == ST_SHIP) && (adp_rise || !dis || exit_evt);
    wire hold_exit = (state_r == ST_HOLD) && (adp_rise || exit_evt);
    wire btn_exit = ((state_r == ST_SHIP) || (state_r == ST_HOLD)) && exit_evt;
    wire tmr_dly_done = tmr_r >= DLY_CYC - 1;
    wire tmr_off_done = tmr_r >= OFF_CYC - 1;
    wire reset_done = (state_r == ST_RST_OFF) && tmr_off_done;
    wire soft_reset = reg_reset_wr || reset_done;

    // battery switch sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_ON: begin
                if (dis && ctrl_r.disable_delay_select) begin
                    state_nxt = ST_DELAY;
                end else if (dis && open_go) begin
                    state_nxt = smr_state_t'(open_tgt);
                end else if (rst_go) begin
                    state_nxt = rst_now ? ST_RST_HIZ : ST_RST_WAIT;
                end
            end
            ST_DELAY: begin
                if (!dis) begin
                    state_nxt = ST_ON;
                end else if (tmr_dly_done && open_go) begin
                    state_nxt = smr_state_t'(open_tgt);
                end
            end
            // switch already open, ship mode follows adapter removal
            ST_OPEN_ADP: begin
                if (!dis) begin
                    state_nxt = ST_ON;
                end else if (!adp) begin
                    state_nxt = ST_SHIP;
                end
            end
            ST_SHIP: state_nxt = ship_exit ? ST_ON : ST_SHIP;
            // button qualified, adapter still attached
            ST_RST_WAIT: begin
                if (!btn_low || !rst_en) begin
                    state_nxt = ST_ON;
                end else if (!adp) begin
                    state_nxt = ST_RST_HIZ;
                end
            end
            ST_RST_HIZ: state_nxt = ST_RST_OFF;
            ST_RST_OFF: begin
                if (tmr_off_done) begin
                    state_nxt = hiz_at_start_r ? ST_HOLD : ST_ON;
                end
            end
            ST_HOLD: state_nxt = hold_exit ? ST_ON : ST_HOLD;
            default: state_nxt = ST_ON;
        endcase
    end

    // control register; hardware set of hiz wins over any clear but a soft reset
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = smr_ctrl_t'(WR_DATA_I[7:0]);
        end
        if (ship_exit || hold_exit) begin
            ctrl_nxt.battery_switch_disable = 1'b0;  // keeps the exit from re-entering
        end
        if (adp_rise) begin
            ctrl_nxt.input_high_impedance_request = 1'b0;
        end
        if (btn_exit) begin
            ctrl_nxt.input_high_impedance_request = 1'b1;
        end
        if (soft_reset) begin
            ctrl_nxt = smr_ctrl_t'(CTRL_RST);
        end
    end

    // state, control and state timer
    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            state_r <= ST_ON;
            ctrl_r <= smr_ctrl_t'(CTRL_RST);
            tmr_r <= 32'h0;
        end else begin
            state_r <= state_nxt;
            ctrl_r <= ctrl_nxt;
            tmr_r <= (state_nxt != state_r) ? 32'h0 : tmr_r + 32'h1;
        end
    end

    // remember hiz request at reset start
    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            hiz_at_start_r <= 1'b0;
        end else if (state_nxt == ST_RST_HIZ && state_r != ST_RST_HIZ) begin
            hiz_at_start_r <= ctrl_r.input_high_impedance_request;
        end
    end

    // free-running blink divider
    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            blink_cnt_r <= 32'h0;
            blink_r <= 1'b0;
        end else if (blink_cnt_r >= BLINK_CYC - 1) begin
            blink_cnt_r <= 32'h0;
            blink_r <= !blink_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + 32'h1;
        end
    end

    // latched fault and status; a read reloads the present value
    wire fault_chg = s_r.fault_flags != s_prev_r.fault_flags;
    wire stat_chg = s_r.status_flags != s_prev_r.status_flags;
    wire pend = |{fault_lat_r, stat_lat_r};
    wire fs_evt = (fault_chg || stat_chg) && !pend;
    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I || soft_reset) begin
            fault_lat_r <= 8'h0;
            stat_lat_r <= 3'h0;
        end else begin
            if (fs_evt || rd_fault) begin
                fault_lat_r <= s_r.fault_flags;
            end
            if (fs_evt || rd_status) begin
                stat_lat_r <= s_r.status_flags;
            end
        end
    end

    // alert sources; overlapping events merge into the running pulse
    wire pg_nxt = s_r.above_uvlo && s_r.above_battery && s_r.below_overvoltage
                  && s_r.not_poor_source && s_r.source_detect_done;
    wire dpm_rise = |(s_r.dpm_active & ~s_prev_r.dpm_active);
    wire alert_trig = (pg_nxt && !pg_r) || adp_fall
                      || (s_r.source_detect_done && !s_prev_r.source_detect_done)
                      || (s_r.terminated && !s_prev_r.terminated)
                      || (dpm_rise && !ctrl_r.dpm_alert_mask)
                      || (s_r.topoff_start && !s_prev_r.topoff_start)
                      || (s_r.topoff_expire && !s_prev_r.topoff_expire)
                      || fs_evt;
    assign alert_cnt_nxt = (alert_cnt_r != 32'h0) ? alert_cnt_r - 32'h1 :
                           alert_trig ? ALERT_CYC : 32'h0;

    // accessory valid and boost; valid falls a cycle before boost may rise
    always_comb begin
        if (boost_r) begin
            apv_nxt = s_r.rail_above_poor_source && s_r.rail_below_overvoltage
                      && !s_r.boost_exit_cause;
        end else begin
            apv_nxt = adp && s_r.above_battery && s_r.below_overvoltage
                      && s_r.not_poor_source && !s_r.direct_path_overcurrent
                      && !s_r.over_accessory_limit;
        end
        boost_nxt = ctrl_r.boost_enable && !adp && !ctrl_r.input_high_impedance_request
                    && sw_on_r && !s_r.boost_exit_cause && (boost_r || !apv_r);
    end

    // charge indicator, pulled low while driven; suspend blink has priority
    assign ind_oe_nxt = s_r.suspend_fault ? blink_r
                        : (s_r.charging && !s_r.terminated && !boost_r);

    // read mux
    wire [31:0] rd_mux = (ADDR_I == OFS_CTRL) ? {24'h0, ctrl_r} :
                         (ADDR_I == OFS_FAULT) ? {24'h0, fault_lat_r} :
                         (ADDR_I == OFS_STATUS) ? {25'h0, stat_lat_r, 1'b0, pg_r,
                                                   s_r.dpm_active} :
                         (ADDR_I == OFS_STATE) ? {25'h0, apv_r, boost_r, hiz_r,
                                                  state_r == ST_SHIP, sw_on_r,
                                                  state_r == ST_RST_OFF, 1'b0} :
                         32'h0;

    // output flops
    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            sw_on_r <= 1'b1;
            hiz_r <= 1'b0;
            pg_r <= 1'b0;
            boost_r <= 1'b0;
            apv_r <= 1'b0;
            ind_oe_r <= 1'b0;
            alert_cnt_r <= 32'h0;
            alert_n_r <= 1'b1;
            rd_data_r <= 32'h0;
        end else begin
            sw_on_r <= !(state_nxt inside {ST_OPEN_ADP, ST_SHIP, ST_RST_OFF, ST_HOLD});
            hiz_r <= ctrl_nxt.input_high_impedance_request
                     || (state_nxt inside {ST_RST_HIZ, ST_RST_OFF});
            pg_r <= pg_nxt;
            boost_r <= boost_nxt;
            apv_r <= apv_nxt;
            ind_oe_r <= ind_oe_nxt;
            alert_cnt_r <= alert_cnt_nxt;
            alert_n_r <= (alert_cnt_nxt == 32'h0);
            rd_data_r <= RD_I ? rd_mux : 32'h0;
        end
    end

    assign BATTERY_SWITCH_ON_O = sw_on_r;
    assign HIZ_MODE_O = hiz_r;
    assign BOOST_ENABLE_O = boost_r;
    assign CHARGE_IND_O = 1'b0;  // open drain: only the enable moves
    assign CHARGE_IND_OE_O = ind_oe_r;
    assign HOST_ALERT_N_O = alert_n_r;
    assign ACCESSORY_POWER_VALID_O = apv_r;
    assign RD_DATA_O = rd_data_r;

    // helper: length of the current alert low phase
    logic [31:0] low_len_r;
    always_ff @(posedge REF_CLK_I) begin
        if (SRST_I || alert_n_r) begin
            low_len_r <= 32'h0;
        end else begin
            low_len_r <= low_len_r + 32'h1;
        end
    end

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (SRST_I);

    a_ship_switch_open: assert property (
        state_r == ST_SHIP |-> !BATTERY_SWITCH_ON_O) else $error("switch closed in ship mode");
    a_direct_open: assert property (
        state_r == ST_ON && dis && !ctrl_r.disable_delay_select && !adp && !soft_reset
        |=> state_r == ST_SHIP ##0 !BATTERY_SWITCH_ON_O) else $error("switch not opened");
    a_adapter_ship: assert property (
        state_r == ST_OPEN_ADP && dis && !adp && !wr_ctrl |=> state_r == ST_SHIP)
        else $error("ship not entered on removal");
    a_button_exit_hiz: assert property (
        state_r == ST_SHIP && exit_evt && !soft_reset
        |=> ctrl_r.input_high_impedance_request && state_r == ST_ON ##1 BATTERY_SWITCH_ON_O)
        else $error("button exit wrong");
    a_reset_gate: assert property (
        state_r == ST_ON && $rose(state_nxt == ST_RST_HIZ || state_nxt == ST_RST_WAIT)
        |-> ctrl_r.system_reset_enable && !dis) else $error("reset while disabled");
    a_hiz_first: assert property (
        state_r == ST_RST_HIZ |-> HIZ_MODE_O && BATTERY_SWITCH_ON_O ##1 !BATTERY_SWITCH_ON_O)
        else $error("hiz not before power cycle");
    a_reset_waits: assert property (
        state_r == ST_RST_WAIT && adp && btn_low && rst_en |=> state_r == ST_RST_WAIT)
        else $error("reset began with adapter");
    a_reset_defaults: assert property (
        reset_done |=> ctrl_r == smr_ctrl_t'(CTRL_RST) && fault_lat_r == 8'h0)
        else $error("registers not at defaults");
    a_power_good: assert property (
        ##1 pg_r == $past(pg_nxt)) else $error("power good mismatch");
    a_alert_width: assert property (
        $rose(HOST_ALERT_N_O) |-> low_len_r == ALERT_CYC) else $error("alert width wrong");
    a_latch_hold: assert property (
        pend && !rd_fault && !soft_reset |=> $stable(fault_lat_r)) else $error("latch moved");
    a_ind_charging: assert property (
        s_r.charging && !s_r.terminated && !s_r.suspend_fault && !boost_r |=> CHARGE_IND_OE_O)
        else $error("indicator not driven");
    a_apv_removal: assert property (
        $rose(BOOST_ENABLE_O) |-> !ACCESSORY_POWER_VALID_O && $past(!apv_r))
        else $error("boost before valid low");

    c_ship_entry: cover property (state_r == ST_ON ##1 state_r == ST_SHIP);
    c_button_exit: cover property (state_r == ST_SHIP && exit_evt);
    c_full_reset: cover property (reset_done);
    c_alert_pulse: cover property ($rose(HOST_ALERT_N_O));
endmodule : smr_top

// File: src/smr_pkg.sv
package smr_pkg;
    // clock rate of the block
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;

    // times in microseconds; the figures without a documented value are plain defaults
    localparam int unsigned EXIT_DEGLITCH_US = 1_000;
    localparam int unsigned RESET_QUALIFY_US = 10_000;
    localparam int unsigned RESET_OFF_US = 250_000;
    localparam int unsigned DISABLE_DELAY_US = 10_000;
    localparam int unsigned ALERT_PULSE_US = 256;
    localparam int unsigned BLINK_HZ = 1;

    // derived cycle counts (exact products, nothing to round)
    localparam int unsigned EXIT_DEGLITCH_CYC = EXIT_DEGLITCH_US * CLK_PER_US;
    localparam int unsigned RESET_QUALIFY_CYC = RESET_QUALIFY_US * CLK_PER_US;
    localparam int unsigned RESET_OFF_CYC = RESET_OFF_US * CLK_PER_US;
    localparam int unsigned DISABLE_DELAY_CYC = DISABLE_DELAY_US * CLK_PER_US;
    localparam int unsigned ALERT_PULSE_CYC = ALERT_PULSE_US * CLK_PER_US;
    localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);

    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FAULT = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_STATE = 8'h0c;

    // control register layout: bits 7:0 are the struct, bit 8 is a write-only reset
    localparam int unsigned REG_RESET_BIT = 8;
    localparam logic [7:0] CTRL_RST = 8'h10;

    typedef struct packed {
        logic dpm_alert_mask;               // bit 7
        logic boost_enable;                 // bit 6
        logic input_high_impedance_request; // bit 5
        logic system_reset_enable;          // bit 4
        logic reset_with_input_select;      // bit 3
        logic ship_with_input_select;       // bit 2
        logic disable_delay_select;         // bit 1
        logic battery_switch_disable;       // bit 0
    } smr_ctrl_t;

    // comparator results and charger status from the analog side
    typedef struct packed {
        logic adapter_present;
        logic above_uvlo;
        logic above_battery;
        logic below_overvoltage;
        logic not_poor_source;
        logic source_detect_done;
        logic direct_path_overcurrent;
        logic over_accessory_limit;
        logic rail_above_poor_source;
        logic rail_below_overvoltage;
        logic boost_exit_cause;
        logic charging;
        logic terminated;
        logic suspend_fault;
        logic topoff_start;
        logic topoff_expire;
        logic [1:0] dpm_active;
        logic [7:0] fault_flags;
        logic [2:0] status_flags;
    } smr_sense_t;
endpackage : smr_pkg

// File: dv/smr_far_model.sv
`timescale 1ns/1ps
// push-button contact and open-drain indicator line beside the block
module smr_far_model (
    input wire logic clk_i,      // block clock
    input wire logic press_i,    // bench asks for the button to be held down
    input wire logic ind_oe_i,   // block pulls the indicator line low
    output logic button_n_o,     // button contact, low while pressed
    output logic ind_pin_o       // indicator line level as an led would see it
);
    // released button rests at its pull-up level
    initial button_n_o = 1'b1;
    // contact follows the press request right after an edge, no bounce modelled
    always @(posedge clk_i) begin
        button_n_o <= ~press_i;
    end
    // pull-up wins whenever the block lets go of the line
    assign ind_pin_o = ind_oe_i ? 1'b0 : 1'b1;
endmodule : smr_far_model

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
    import smr_pkg::*;
    localparam int OFF = 8; // short reset off-time used here
    localparam int ALR = 6; // short alert width used here
    localparam int BLK = 4; // short blink half period used here
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic press = 1'b0;
    smr_sense_t sense = '0;
    logic [31:0] rdata, got;
    logic sw_on, input_high_impedance_mode, boost, ind, ind_oe, alert_n, apv, btn_n, ind_pin;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    int n, k;
    // 25 MHz clock
    always #20 clk = ~clk;
    smr_top #(.EXIT_CYC(4), .QUAL_CYC(10), .OFF_CYC(OFF), .DLY_CYC(5), .ALERT_CYC(ALR),
        .BLINK_CYC(BLK)) i_smr_top (.REF_CLK_I(clk), .SRST_I(srst), .ADDR_I(addr),
        .WR_DATA_I(wdata), .WR_I(wr), .RD_I(rd), .RD_DATA_O(rdata), .PUSH_BUTTON_N_I(btn_n),
        .SENSE_I(sense), .BATTERY_SWITCH_ON_O(sw_on), .HIZ_MODE_O(input_high_impedance_mode), .BOOST_ENABLE_O(boost),
        .CHARGE_IND_O(ind), .CHARGE_IND_OE_O(ind_oe), .HOST_ALERT_N_O(alert_n),
        .ACCESSORY_POWER_VALID_O(apv));
    smr_far_model i_smr_far_model (.clk_i(clk), .press_i(press), .ind_oe_i(ind_oe),
        .button_n_o(btn_n), .ind_pin_o(ind_pin));
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            $display("ERROR %0t: run did not finish", $time);
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int c);
        repeat (c) begin
            @(posedge clk);
            #1;
        end
    endtask : tick
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    function automatic logic pick(input int s);
        case (s)
            0: return alert_n;
            1: return sw_on;
            2: return ind_pin;
            3: return apv;
            5: return boost;
            default: return input_high_impedance_mode;
        endcase
    endfunction : pick
    // bounded wait for a level; the caller compares afterwards
    task automatic wait_lvl(input int s, input logic v);
        int t;
        t = 0;
        while (pick(s) !== v && t < 40) begin
            tick(1);
            t++;
        end
    endtask : wait_lvl
    // length in cycles of the next stretch at level v
    task automatic run_len(input int s, input logic v, output int c);
        wait_lvl(s, v);
        c = 0;
        while (pick(s) === v && c < 60) begin
            tick(1);
            c++;
        end
    endtask : run_len
    task automatic hold_button(input int c);
        @(posedge clk);
        press <= 1'b1;
        tick(c);
        @(posedge clk);
        press <= 1'b0;
    endtask : hold_button
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done
    initial begin
        tick(5);
        srst <= 1'b0;
        rd_reg(OFS_CTRL, got);
        chk(got, 32'h10);
        rd_reg(OFS_STATE, got);
        chk(got, 32'h4);
        rd_reg(8'h10, got);
        chk(got, 32'h0);
        done("reset values");
        // ship entry, then exit by the button
        wr_reg(OFS_CTRL, 32'h01);
        tick(2);
        chk(sw_on, 1'b0);
        hold_button(8);
        wait_lvl(1, 1'b1);
        chk(sw_on, 1'b1);
        rd_reg(OFS_CTRL, got);
        chk(got, 32'h20);
        sense.adapter_present <= 1'b1;
        tick(6);
        rd_reg(OFS_CTRL, got);
        chk(got, 32'h00);
        done("button exit");
        // host sets the with-input bit before the disable bit
        wr_reg(OFS_CTRL, 32'h04);
        wr_reg(OFS_CTRL, 32'h05);
        wait_lvl(1, 1'b0);
        chk(sw_on, 1'b0);
        sense.adapter_present <= 1'b0;
        tick(4);
        rd_reg(OFS_STATE, got);
        chk(got, 32'h8);
        wr_reg(OFS_CTRL, 32'h100);
        wait_lvl(1, 1'b1);
        chk(sw_on, 1'b1);
        rd_reg(OFS_CTRL, got);
        chk(got, 32'h10);
        sense.adapter_present <= 1'b0;
        done("ship with adapter");
        wr_reg(OFS_CTRL, 32'h03);
        tick(3);
        chk(sw_on, 1'b1);
        wait_lvl(1, 1'b0);
        chk(sw_on, 1'b0);
        wr_reg(OFS_CTRL, 32'h00);
        wait_lvl(1, 1'b1);
        chk(sw_on, 1'b1);
        done("delayed ship");
        // long presses that must not power cycle
        for (k = 0; k < 2; k++) begin
            wr_reg(OFS_CTRL, k ? 32'h08 : 32'h10);
            sense.adapter_present <= (k == 0);
            hold_button(20);
            chk(sw_on, 1'b1);
            tick(4);
        end
        done("reset refused");
        wr_reg(OFS_CTRL, 32'h18);
        sense.adapter_present <= 1'b1;
        @(posedge clk);
        press <= 1'b1;
        wait_lvl(4, 1'b1);
        chk(input_high_impedance_mode, 1'b1);
        chk(sw_on, 1'b1);
        run_len(1, 1'b0, n);
        chk(n, OFF);
        press <= 1'b0;
        rd_reg(OFS_CTRL, got);
        chk(got, 32'h10);
        done("reset with input");
        wr_reg(OFS_CTRL, 32'h30);
        sense.adapter_present <= 1'b0;
        hold_button(16);
        tick(OFF + 10);
        chk(sw_on, 1'b0);
        sense.adapter_present <= 1'b1;
        wait_lvl(1, 1'b1);
        chk(sw_on, 1'b1);
        done("reset with hiz");
        sense.adapter_present <= 1'b0;
        for (k = 0; k < 6; k++) begin
            {sense.above_uvlo, sense.above_battery, sense.below_overvoltage,
                sense.not_poor_source, sense.source_detect_done} <= 5'h1f >> k;
            tick(4);
            rd_reg(OFS_STATUS, got);
            chk(got & 32'h4, k ? 32'h0 : 32'h4);
        end
        done("power good");
        tick(10);
        sense.fault_flags <= 8'h20;
        run_len(0, 1'b0, n);
        chk(n, ALR);
        sense.fault_flags <= 8'h00;
        tick(6);
        chk(alert_n, 1'b1);
        rd_reg(OFS_FAULT, got);
        chk(got, 32'h20);
        rd_reg(OFS_FAULT, got);
        chk(got, 32'h00);
        sense.fault_flags <= 8'h04;
        run_len(0, 1'b0, n);
        chk(n, ALR);
        done("alert latch");
        sense.adapter_present <= 1'b1;
        {sense.above_battery, sense.below_overvoltage, sense.not_poor_source} <= 3'h7;
        wait_lvl(3, 1'b1);
        chk(apv, 1'b1);
        sense.direct_path_overcurrent <= 1'b1;
        wait_lvl(3, 1'b0);
        chk(apv, 1'b0);
        sense.direct_path_overcurrent <= 1'b0;
        wait_lvl(3, 1'b1);
        sense.adapter_present <= 1'b0;
        wait_lvl(3, 1'b0);
        chk(apv, 1'b0);
        wr_reg(OFS_CTRL, 32'h40);
        wait_lvl(5, 1'b1);
        chk(boost, 1'b1);
        {sense.rail_above_poor_source, sense.rail_below_overvoltage} <= 2'h3;
        wait_lvl(3, 1'b1);
        chk(apv, 1'b1);
        wr_reg(OFS_CTRL, 32'h00);
        wait_lvl(3, 1'b0);
        chk({boost, apv}, 2'b00);
        done("accessory valid");
        sense.charging <= 1'b1;
        wait_lvl(2, 1'b0);
        chk({ind, ind_pin}, 2'b00);
        sense.terminated <= 1'b1;
        wait_lvl(2, 1'b1);
        chk(ind_pin, 1'b1);
        sense.suspend_fault <= 1'b1;
        run_len(2, 1'b0, n);
        run_len(2, 1'b1, n);
        chk(n, BLK);
        done("indicator");
        wrap_up();
    end
endmodule : tb
